// ===== gate_scan_pulse_logic.sv
// module: scan driver logic turning timing-controller pins into gate and start pulses
`timescale 1ns/100ps
module gate_scan_pulse_logic
  import gate_scan_pkg::*;
(
  input  wire logic clk_sys_i,             // system clock, 100 MHz
  input  wire logic rst_n_i,               // async reset, active low
  input  wire logic frame_sync_in_i,       // frame sync pin
  input  wire logic vert_clock_in_i,       // vertical clock pin
  input  wire logic pulse_en_i,            // gate pulse enable pin
  input  wire logic enable_mask_in_i,      // rc-filtered enable pin
  output logic      gate_pulse_out_o,      // true gate pulse level
  output logic      gate_pulse_out_oe_o,   // true gate pulse driven
  output logic      gate_pulse_out_inv_o,  // inverse gate pulse level
  output logic      gate_pulse_out_inv_oe_o, // inverse gate pulse driven
  output logic      share_node_true_o,     // true output tied to share node
  output logic      share_node_inv_o,      // inverse output tied to share node
  output logic      start_pulse_out_o,     // start pulse level
  output logic      start_pulse_out_oe_o   // start pulse driven
);

  // three-stage synchronisers; a change counts once stages 1 and 2 agree
  // limitation: a pin level shorter than two edges is never seen
  logic [SYNC_STAGES-1:0] sync_reg [4];
  logic [3:0]             pin_raw;
  scan_in_t               filt_reg;
  scan_in_t               filt_prev_reg;

  assign pin_raw = {frame_sync_in_i, vert_clock_in_i, pulse_en_i, enable_mask_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // shift chain per pin; stage 0 feeds only stage 1
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync_reg[gi] <= '0;
        end else begin
          sync_reg[gi] <= {sync_reg[gi][SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
    end
  endgenerate

  // accept a new level only when the last two stages agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_reg <= '0;
    end else begin
      if (sync_reg[3][2] == sync_reg[3][1]) begin
        filt_reg.frame_sync_in <= sync_reg[3][2];
      end
      if (sync_reg[2][2] == sync_reg[2][1]) begin
        filt_reg.vert_clock_in <= sync_reg[2][2];
      end
      if (sync_reg[1][2] == sync_reg[1][1]) begin
        filt_reg.pulse_en <= sync_reg[1][2];
      end
      if (sync_reg[0][2] == sync_reg[0][1]) begin
        filt_reg.enable_mask_in <= sync_reg[0][2];
      end
    end
  end

  // previous filtered levels for edge detection
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_prev_reg <= '0;
    end else begin
      filt_prev_reg <= filt_reg;
    end
  end

  logic clk_fall;
  logic en_rise;
  logic mask_reg;
  logic en_eff;

  assign clk_fall = filt_prev_reg.vert_clock_in & ~filt_reg.vert_clock_in;

  // mask latch: once the filtered enable crosses threshold, hold off the
  // enable until both enable and mask are low again
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_reg <= 1'b0;
    end else if (filt_reg.enable_mask_in) begin
      mask_reg <= 1'b1;
    end else if (!filt_reg.pulse_en) begin
      mask_reg <= 1'b0;
    end
  end

  assign en_eff  = filt_reg.pulse_en & ~mask_reg & ~filt_reg.enable_mask_in;
  assign en_rise = en_eff & ~(filt_prev_reg.pulse_en & ~mask_reg);

  // phase of the gate pulse: flips on each falling vertical clock edge after the first enable rise
  logic phase_reg;
  logic started_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= RST_PHASE;
    end else if (clk_fall && started_reg) begin
      phase_reg <= ~phase_reg;
    end
  end

  // drive state: off until the first enable rise, then follows the pins
  logic active_reg;
  logic hiz_cond;

  // hi-z when clock low and enable low, or clock low and mask high
  assign hiz_cond = ~filt_reg.vert_clock_in &
                    (~filt_reg.pulse_en | filt_reg.enable_mask_in);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      started_reg <= 1'b0;
    end else if (en_rise) begin
      started_reg <= 1'b1;
    end
  end

  // fall and enable rise on one edge: the fall wins so the new level never
  // lands on driven outputs; the rise is kept and re-drives a cycle later
  logic redrive_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      redrive_reg <= 1'b0;
    end else begin
      redrive_reg <= en_rise & clk_fall;
    end
  end

  // a clock fall always drops to sharing first; enable rise re-drives
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_reg <= RST_ACTIVE;
    end else if (clk_fall) begin
      active_reg <= 1'b0;
    end else if (en_rise) begin
      active_reg <= 1'b1;
    end else if (hiz_cond || !started_reg) begin
      active_reg <= 1'b0;
    end else if (redrive_reg || filt_reg.vert_clock_in) begin
      active_reg <= 1'b1;
    end
  end

  hv_pin_t gate_reg;
  hv_pin_t start_reg;

  // registered gate output; inverse derived from same flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_reg <= '0;
    end else begin
      gate_reg.level <= phase_reg;
      gate_reg.oe    <= active_reg;
    end
  end

  // start pulse: low / high / hi-z from frame sync, clock and enable
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_reg <= '{level: 1'b0, oe: 1'b1};
    end else if (!filt_reg.frame_sync_in) begin
      start_reg <= '{level: 1'b0, oe: 1'b1};
    end else if (!filt_reg.vert_clock_in && !filt_reg.pulse_en) begin
      start_reg <= '{level: 1'b1, oe: 1'b1};
    end else begin
      start_reg <= '{level: 1'b0, oe: 1'b0};
    end
  end

  assign gate_pulse_out_o        = gate_reg.level & gate_reg.oe;
  assign gate_pulse_out_oe_o     = gate_reg.oe;
  assign gate_pulse_out_inv_o    = ~gate_reg.level & gate_reg.oe;
  assign gate_pulse_out_inv_oe_o = gate_reg.oe;
  assign share_node_true_o       = ~gate_reg.oe;
  assign share_node_inv_o        = ~gate_reg.oe;
  assign start_pulse_out_o       = start_reg.level;
  assign start_pulse_out_oe_o    = start_reg.oe;

  // checks
  property p_inv_mirror;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      gate_pulse_out_oe_o |-> (gate_pulse_out_inv_o == !gate_pulse_out_o);
  endproperty
  a_inv_mirror: assert property (p_inv_mirror) else $error("inverse mismatch");

  property p_share_true;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      share_node_true_o == !gate_pulse_out_oe_o;
  endproperty
  a_share_true: assert property (p_share_true) else $error("share true wrong");

  property p_share_inv;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      share_node_inv_o == !gate_pulse_out_inv_oe_o;
  endproperty
  a_share_inv: assert property (p_share_inv) else $error("share inv wrong");

  property p_start_low;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !filt_reg.frame_sync_in |=> (start_pulse_out_oe_o && !start_pulse_out_o);
  endproperty
  a_start_low: assert property (p_start_low) else $error("start not low");

  property p_start_high;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (filt_reg.frame_sync_in && !filt_reg.vert_clock_in && !filt_reg.pulse_en)
        |=> (start_pulse_out_oe_o && start_pulse_out_o);
  endproperty
  a_start_high: assert property (p_start_high) else $error("start not high");

  property p_start_hiz;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (filt_reg.frame_sync_in && (filt_reg.vert_clock_in || filt_reg.pulse_en))
        |=> !start_pulse_out_oe_o;
  endproperty
  a_start_hiz: assert property (p_start_hiz) else $error("start not hi-z");

  property p_fall_shares;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk_fall && !en_rise) |=> ##1 !gate_pulse_out_oe_o;
  endproperty
  a_fall_shares: assert property (p_fall_shares) else $error("no share on fall");

  property p_flip;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk_fall && started_reg) |=> (phase_reg != $past(phase_reg));
  endproperty
  a_flip: assert property (p_flip) else $error("phase did not flip");

  property p_en_rise_drive;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (en_rise && !clk_fall) |=> ##1 gate_pulse_out_oe_o;
  endproperty
  a_en_rise_drive: assert property (p_en_rise_drive) else $error("no drive on enable");

  property p_idle_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!started_reg && !en_rise) |=> ##1 !gate_pulse_out_oe_o;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("driven before start");

  property p_mask_block;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      mask_reg |-> !en_eff;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("mask ignored");

  property p_hiz_cond;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (hiz_cond && !en_rise) |=> ##1 !gate_pulse_out_oe_o;
  endproperty
  a_hiz_cond: assert property (p_hiz_cond) else $error("not hi-z when idle");

  // fall and enable rise together: share one cycle, then drive
  property p_fall_redrive;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (en_rise && clk_fall) |=> ##1 !gate_pulse_out_oe_o ##1 gate_pulse_out_oe_o;
  endproperty
  a_fall_redrive: assert property (p_fall_redrive) else $error("late re-drive");

  // a level change always passes through sharing first
  property p_level_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (gate_pulse_out_oe_o && $past(gate_pulse_out_oe_o)) |-> $stable(gate_pulse_out_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("moved while driven");

  // an enable rise under the latched mask, with the clock low, leaves the outputs sharing
  property p_mask_ignore;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mask_reg && $rose(filt_reg.pulse_en) && !filt_reg.vert_clock_in)
        |=> ##1 !gate_pulse_out_oe_o;
  endproperty
  a_mask_ignore: assert property (p_mask_ignore) else $error("enable not masked");

  // main scenarios reached

  c_en_rise: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) en_rise);
  c_flip: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) clk_fall && started_reg);
  c_start_high: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                                start_pulse_out_oe_o && start_pulse_out_o);
  c_masked: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) mask_reg);
  c_redrive: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) redrive_reg);

endmodule

// ===== gate_scan_pkg.sv
// package: shared constants and carrier types for the gate scan pulse logic
package gate_scan_pkg;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // drive levels at reset
  localparam logic RST_PHASE  = 1'b0;   // first driven level of the true output
  localparam logic RST_ACTIVE = 1'b0;   // outputs start in charge-sharing state

  // filtered pin levels from the timing controller
  typedef struct packed {
    logic frame_sync_in;   // start of frame, high active
    logic vert_clock_in;   // vertical clock
    logic pulse_en;        // gate pulse enable
    logic enable_mask_in;  // rc-filtered copy of enable
  } scan_in_t;

  // one high-voltage output: value plus enable
  typedef struct packed {
    logic level;  // 1 = high rail, 0 = low rail
    logic oe;     // 1 = driven, 0 = high impedance
  } hv_pin_t;

endpackage

// ===== scan_ctrl_model.sv
// partner: timing controller model driving the scan control pins
`timescale 1ns/100ps
module scan_ctrl_model #(
  parameter int HOLD = 8  // cycles a level stands, well above the 3-edge filter
) (
  input  wire logic clk_sys_i,      // system clock
  output logic      frame_sync_o,   // frame sync pin
  output logic      vert_clock_o,   // vertical clock pin
  output logic      pulse_en_o,     // gate pulse enable pin
  output logic      enable_mask_o   // rc-filtered enable pin
);
  // pins idle low, as a controller holds them before the first frame
  initial begin
    frame_sync_o  = 1'b0;
    vert_clock_o  = 1'b0;
    pulse_en_o    = 1'b0;
    enable_mask_o = 1'b0;
  end

  // change pins off the sampling edge, then hold so the filter accepts them
  task automatic put(input logic fs, input logic vc, input logic en, input logic mk);
    @(negedge clk_sys_i);
    frame_sync_o  = fs;  // a rise here opens a frame
    vert_clock_o  = vc;
    pulse_en_o    = en;
    enable_mask_o = mk;
    repeat (HOLD) @(negedge clk_sys_i);
  endtask
endmodule

// ===== gate_scan_pulse_logic_tb.sv
// testbench: scoreboard checks of gate and start pulse outputs
`timescale 1ns/100ps
module gate_scan_pulse_logic_tb;
  import gate_scan_pkg::*;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        fs, vc, en, mk;
  logic        gp, gp_oe, gi, gi_oe, sh_t, sh_i, sp, sp_oe;
  logic [7:0]  outs;
  logic [15:0] notes[$];
  int          fail_count, checks_done, cycles;
  event        ev;

  assign outs = {gp, gp_oe, gi, gi_oe, sh_t, sh_i, sp, sp_oe};

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  scan_ctrl_model scan_ctrl_model_i (
    .clk_sys_i     (clk_sys_i),
    .frame_sync_o  (fs),
    .vert_clock_o  (vc),
    .pulse_en_o    (en),
    .enable_mask_o (mk)
  );

  gate_scan_pulse_logic gate_scan_pulse_logic_i (
    .clk_sys_i               (clk_sys_i),
    .rst_n_i                 (rst_n_i),
    .frame_sync_in_i         (fs),
    .vert_clock_in_i         (vc),
    .pulse_en_i              (en),
    .enable_mask_in_i        (mk),
    .gate_pulse_out_o        (gp),
    .gate_pulse_out_oe_o     (gp_oe),
    .gate_pulse_out_inv_o    (gi),
    .gate_pulse_out_inv_oe_o (gi_oe),
    .share_node_true_o       (sh_t),
    .share_node_inv_o        (sh_i),
    .start_pulse_out_o       (sp),
    .start_pulse_out_oe_o    (sp_oe)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pins {sync, clock, enable, mask}; note the expectation once pins settled
  task automatic step(input logic [3:0] p, input logic [7:0] e, input logic [7:0] m);
    scan_ctrl_model_i.put(p[3], p[2], p[1], p[0]);
    notes.push_back({e & m, m});
    -> ev;
  endtask

  // watcher: oldest note against the outputs, masked bits left open
  always @(ev) begin : watch
    logic [15:0] n;
    n = notes.pop_front();
    check(outs & n[7:0], n[15:8]);
  end

  // hang guard, ceiling far above the ~40 steps of 9 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin : main
    logic [2:0] r;
    logic [3:0] p;
    rst_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    void'($urandom(32'hA0C3E962));
    // gate scan: idle, enable, clock falls, disable, mask
    step(4'b0000, 8'h0D, 8'hFF);
    step(4'b0100, 8'h0D, 8'hFF);
    step(4'b0110, 8'h71, 8'hFF);
    step(4'b0010, 8'h0D, 8'hFF);
    step(4'b0110, 8'hD1, 8'hFF);
    step(4'b0010, 8'h0D, 8'hFF);
    step(4'b0110, 8'h71, 8'hFF);
    step(4'b0000, 8'h0D, 8'hFF);
    step(4'b0110, 8'hD1, 8'hFF);
    step(4'b0011, 8'h0D, 8'hFF);
    step(4'b0001, 8'h0D, 8'hFF);
    step(4'b0010, 8'h0D, 8'hFF);
    step(4'b0000, 8'h0D, 8'hFF);
    step(4'b0110, 8'h71, 8'hFF);
    step(4'b0000, 8'h0D, 8'hFF);
    step(4'b0100, 8'hD1, 8'hFF);
    step(4'b0010, 8'h71, 8'hFF);
    step(4'b0000, 8'h0D, 8'hFF);
    $display("test gate scan done");
    // start pulse: every sync/clock/enable code, then random ones
    for (int i = 0; i < 20; i++) begin
      r = (i < 8) ? i[2:0] : 3'($urandom);
      p = {r, 1'b0};
      step(p, r[2] ? ((r[1] | r[0]) ? 8'h00 : 8'h03) : 8'h01,
           (r[2] & (r[1] | r[0])) ? 8'h01 : 8'h03);
    end
    $display("test start pulse done");
    repeat (2) @(negedge clk_sys_i);
    end_sim();
  end
endmodule
